// ---- common/riw_defines.vh ----
`ifndef RIW_DEFINES_VH
`define RIW_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define RIW_REG_CTRL 8'h00
`define RIW_REG_RXLEN 8'h04
`define RIW_REG_RING_EN 8'h08
`define RIW_REG_STATUS 8'h0c
`define RIW_REG_DST_LO 8'h10
`define RIW_REG_DST_HI 8'h14
`define RIW_REG_RX_LO 8'h18
`define RIW_REG_RX_HI 8'h1c

// ****************************************
// register fields and reset values
// ****************************************
`define RIW_CTRL_RAL 0
`define RIW_CTRL_WIDE 1
`define RIW_CTRL_RST 2'h0
`define RIW_RXLEN_RST 14'h0800
`define RIW_RING_EN_RST 8'hff
`define RIW_STAT_ALIGN 0
`define RIW_STAT_DISC 1

// ****************************************
// buffer descriptor fields
// ****************************************
`define RIW_DESC_DISCARD 62
`define RIW_DESC_LEN_HI 39
`define RIW_DESC_LEN_LO 32
`define RIW_DESC_ADDR_LO2 2
`define RIW_SRC_TAG_HI 59
`define RIW_SRC_TAG_LO 48
`define RIW_SRC_CMD_HI 47
`define RIW_SRC_CMD_LO 45

// ****************************************
// indication word fields
// ****************************************
`define RIW_IND_KIND_HI 63
`define RIW_IND_KIND_LO 60
`define RIW_IND_SINGLE 59
`define RIW_IND_SPLIT 58
`define RIW_IND_CRC 57
`define RIW_IND_OVR 57
`define RIW_IND_PAR 56
`define RIW_IND_FLAGS_HI 55
`define RIW_IND_FLAGS_LO 48
`define RIW_IND_PER_HI 54
`define RIW_IND_PER_LO 52
`define RIW_IND_CMD_HI 47
`define RIW_IND_CMD_LO 45
`define RIW_IND_DMC_HI 47
`define RIW_IND_DMC_LO 46
`define RIW_IND_STT_HI 42
`define RIW_IND_STT_LO 40
`define RIW_IND_TAG_HI 35
`define RIW_IND_TAG_LO 24
`define RIW_IND_MK_HI 23
`define RIW_IND_DMA_LEN_HI 12
`define RIW_IND_RX_LEN_HI 15

// ****************************************
// indication kinds
// ****************************************
`define RIW_KIND_DMA_OK 4'h1
`define RIW_KIND_DMA_ERR 4'h2
`define RIW_KIND_MAKE 4'h3
`define RIW_KIND_RX_NORM 4'h4
`define RIW_KIND_RX_ERR 4'h5

// ****************************************
// codes
// ****************************************
`define RIW_PER_SRC_ABORT 3'b001
`define RIW_PER_SRC_PARITY 3'b010
`define RIW_PER_DST_ABORT 3'b100
`define RIW_PER_DST_PARITY 3'b111
`define RIW_DMC_RESERVED 2'b00
`define RIW_DMC_PROMISC 2'b10
`define RIW_DMC_CAM 2'b01
`define RIW_DMC_LOCAL 2'b11
`define RIW_STT_SECONDARY 3'b000
`define RIW_STT_SA_MATCH 3'b001
`define RIW_STT_DA_NOMATCH 3'b010
`define RIW_STT_DEV_ABORT 3'b011
`define RIW_STT_BAD_LEN 3'b100
`define RIW_STT_FRAGMENT 3'b101
`define RIW_STT_FORMAT 3'b110
`define RIW_STT_MAC_RESET 3'b111
`define RIW_BUF_MIN 14'h0040

`endif

// ---- rtl/riw_ring_indication_writer.v ----
// Contract
// R1: destination discard aborts the rest of the DMA frame.
// R2: error-free DMA frame writes a success indication.
// R3: indication takes user_tag of the final source descriptor.
// R4: source command bits 47..45 copied into indication.
// R5: success length is frame bytes modulo 8K.
// R6: abort code 001 source side, 100 destination side or discard.
// R7: parity code 010 source side, 111 destination side.
// R8: make-indication 24-bit field copied unchanged.
// R9: one-hot length field, 64 bytes doubling up to 8K.
// R10: zero length field uses the receive buffer length register.
// R11: software aligns buffers to the access width.
// R12: receive discard drops the rest of the frame.
// R13: normal indication even on CRC error, crc_error_flag set.
// R14: split_flag set in both split parts, clear otherwise.
// R15: single_buffer_flag 1 for one buffer, 0 for several.
// R16: dest_match_code 00 reserved, 10 promiscuous, 01 CAM, 11 local.
// R17: split mode reports header and data lengths separately.
// R18: header status fields invalid in split mode.
// R19: error indication only under receive_all_mode, device abort or long fragment; the code also writes one on overrun.
// R20: overrun sets overrun_flag and disables that ring's receiver.
// R21: 3-bit mac_receive_status encoding.
// R22: MAC interface error zeros bits 55..48 of the error indication.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "riw_defines.vh"

module riw_ring_indication_writer #(
    parameter RINGS = 8,
    parameter TAG_W = 12
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_r,
    // destination / receive descriptor fetch
    input wire desc_valid,
    input wire desc_is_rx,
    input wire [63:0] desc_word,
    output reg [13:0] buf_len_r,
    output reg buf_len_valid_r,
    output reg dma_discard_r,
    output reg rx_discard_r,
    // dma frame end
    input wire dma_end,
    input wire [63:0] dma_src_desc,
    input wire [15:0] dma_byte_count,
    input wire dma_single_buf,
    input wire dma_src_abort,
    input wire dma_src_parity,
    input wire dma_dst_abort,
    input wire dma_dst_parity,
    // make indication command
    input wire mk_ind,
    input wire [23:0] mk_ind_field,
    // destination ring indication
    output reg dst_ind_valid_r,
    output reg [63:0] dst_ind_word_r,
    // receive frame end
    input wire rx_end,
    input wire [2:0] rx_ring,
    input wire [15:0] rx_byte_count,
    input wire rx_single_buf,
    input wire rx_split,
    input wire rx_header_part,
    input wire rx_crc_err,
    input wire [7:0] rx_flags,
    input wire rx_match_local,
    input wire rx_match_cam,
    input wire rx_match_promisc,
    input wire [2:0] rx_mac_status,
    input wire rx_err_frame,
    input wire rx_dev_abort,
    input wire rx_frag_over_wm,
    input wire rx_overrun,
    input wire rx_parity,
    input wire rx_mac_side_interface_err,
    // receive ring indication and ring state
    output reg rx_ind_valid_r,
    output reg [63:0] rx_ind_word_r,
    output reg [RINGS-1:0] rx_ring_en_r
);

    // ****************************************
    // functions
    // ****************************************
    // lowest set bit wins, so a malformed field still gives one size
    function [13:0] buf_decode;
        input [7:0] code;
        input [13:0] dflt;
        integer i;
        begin
            buf_decode = dflt; // [R10]
            for (i = 7; i >= 0; i = i - 1) begin
                if (code[i]) begin
                    buf_decode = `RIW_BUF_MIN << i; // [R9]
                end
            end
        end
    endfunction

    function [1:0] dmc_encode;
        input local_m;
        input cam_m;
        input promisc_m;
        begin
            if (local_m) begin
                dmc_encode = `RIW_DMC_LOCAL; // [R16]
            end else if (cam_m) begin
                dmc_encode = `RIW_DMC_CAM; // [R16]
            end else if (promisc_m) begin
                dmc_encode = `RIW_DMC_PROMISC; // [R16]
            end else begin
                dmc_encode = `RIW_DMC_RESERVED;
            end
        end
    endfunction

    // ****************************************
    // registers
    // ****************************************
    reg [1:0] ctrl_r;
    reg [13:0] rxlen_r;
    reg align_err_r;
    reg dma_disc_pend_r;
    reg [63:0] dst_ind_nxt;
    reg [63:0] rx_ind_nxt;
    reg rx_ind_go;
    reg [2:0] per_nxt;
    reg dma_err;
    reg [RINGS-1:0] ring_en_nxt;

    wire desc_discard = desc_valid & desc_word[`RIW_DESC_DISCARD];
    wire dma_disc_now = dma_disc_pend_r | (desc_discard & ~desc_is_rx);
    wire misaligned = ctrl_r[`RIW_CTRL_WIDE] ? (desc_word[`RIW_DESC_ADDR_LO2:0] != 3'h0)
                                              : (desc_word[1:0] != 2'h0);
    wire rx_ring_on = rx_ring_en_r[rx_ring];
    wire rx_err_case = (rx_err_frame & ctrl_r[`RIW_CTRL_RAL]) | rx_dev_abort
                       | rx_frag_over_wm | rx_overrun;
    wire hdr_invalid = rx_split & rx_header_part;

    // ****************************************
    // dma indication build
    // ****************************************
    always @* begin
        per_nxt = 3'h0;
        dma_err = 1'b1;
        if (dma_dst_parity) begin
            per_nxt = `RIW_PER_DST_PARITY; // [R7]
        end else if (dma_dst_abort | dma_disc_now) begin
            per_nxt = `RIW_PER_DST_ABORT; // [R6] [R1]
        end else if (dma_src_parity) begin
            per_nxt = `RIW_PER_SRC_PARITY; // [R7]
        end else if (dma_src_abort) begin
            per_nxt = `RIW_PER_SRC_ABORT; // [R6]
        end else begin
            dma_err = 1'b0;
        end
        dst_ind_nxt = 64'h0;
        if (dma_end) begin
            dst_ind_nxt[`RIW_IND_SINGLE] = dma_single_buf; // [R15]
            dst_ind_nxt[`RIW_IND_TAG_HI:`RIW_IND_TAG_LO] =
                dma_src_desc[`RIW_SRC_TAG_HI:`RIW_SRC_TAG_LO]; // [R3]
            dst_ind_nxt[`RIW_IND_CMD_HI:`RIW_IND_CMD_LO] =
                dma_src_desc[`RIW_SRC_CMD_HI:`RIW_SRC_CMD_LO]; // [R4]
            if (dma_err) begin
                dst_ind_nxt[`RIW_IND_KIND_HI:`RIW_IND_KIND_LO] = `RIW_KIND_DMA_ERR;
                dst_ind_nxt[`RIW_IND_PER_HI:`RIW_IND_PER_LO] = per_nxt; // [R6] [R7]
            end else begin
                dst_ind_nxt[`RIW_IND_KIND_HI:`RIW_IND_KIND_LO] = `RIW_KIND_DMA_OK; // [R2]
                dst_ind_nxt[`RIW_IND_DMA_LEN_HI:0] =
                    dma_byte_count[`RIW_IND_DMA_LEN_HI:0]; // [R5]
            end
        end else if (mk_ind) begin
            dst_ind_nxt[`RIW_IND_KIND_HI:`RIW_IND_KIND_LO] = `RIW_KIND_MAKE;
            dst_ind_nxt[`RIW_IND_MK_HI:0] = mk_ind_field; // [R8]
        end
    end

    // ****************************************
    // receive indication build
    // ****************************************
    always @* begin
        rx_ind_nxt = 64'h0;
        rx_ind_go = 1'b0;
        ring_en_nxt = rx_ring_en_r;
        if (rx_end & rx_ring_on) begin
            rx_ind_nxt[`RIW_IND_SINGLE] = rx_single_buf; // [R15]
            rx_ind_nxt[`RIW_IND_SPLIT] = rx_split; // [R14]
            rx_ind_nxt[`RIW_IND_RX_LEN_HI:0] = rx_byte_count; // [R17]
            if (rx_err_case) begin
                rx_ind_go = 1'b1; // [R19]
                rx_ind_nxt[`RIW_IND_KIND_HI:`RIW_IND_KIND_LO] = `RIW_KIND_RX_ERR;
                rx_ind_nxt[`RIW_IND_OVR] = rx_overrun; // [R20]
                rx_ind_nxt[`RIW_IND_PAR] = rx_parity;
                if (!rx_mac_side_interface_err && !hdr_invalid) begin
                    rx_ind_nxt[`RIW_IND_FLAGS_HI:`RIW_IND_FLAGS_LO] = rx_flags; // [R22]
                end
                if (rx_dev_abort) begin
                    rx_ind_nxt[`RIW_IND_STT_HI:`RIW_IND_STT_LO] = `RIW_STT_DEV_ABORT; // [R21]
                end else if (rx_frag_over_wm) begin
                    rx_ind_nxt[`RIW_IND_STT_HI:`RIW_IND_STT_LO] = `RIW_STT_FRAGMENT; // [R21]
                end else if (!hdr_invalid) begin
                    rx_ind_nxt[`RIW_IND_STT_HI:`RIW_IND_STT_LO] = rx_mac_status; // [R21]
                end
                if (rx_overrun) begin
                    ring_en_nxt[rx_ring] = 1'b0; // [R20]
                end
            end else if (!rx_err_frame) begin
                rx_ind_go = 1'b1; // [R13]
                rx_ind_nxt[`RIW_IND_KIND_HI:`RIW_IND_KIND_LO] = `RIW_KIND_RX_NORM;
                if (!hdr_invalid) begin
                    rx_ind_nxt[`RIW_IND_CRC] = rx_crc_err; // [R13] [R18]
                    rx_ind_nxt[`RIW_IND_FLAGS_HI:`RIW_IND_FLAGS_LO] = rx_flags; // [R18]
                    rx_ind_nxt[`RIW_IND_DMC_HI:`RIW_IND_DMC_LO] =
                        dmc_encode(rx_match_local, rx_match_cam, rx_match_promisc); // [R16]
                end
            end
        end
    end

    // ****************************************
    // descriptor path
    // ****************************************
    always @(posedge clk) begin
        if (!rst_b) begin
            buf_len_r <= 14'h0;
            buf_len_valid_r <= 1'b0;
            dma_discard_r <= 1'b0;
            rx_discard_r <= 1'b0;
            dma_disc_pend_r <= 1'b0;
        end else begin
            buf_len_valid_r <= desc_valid;
            dma_discard_r <= desc_discard & ~desc_is_rx; // [R1]
            rx_discard_r <= desc_discard & desc_is_rx; // [R12]
            if (desc_valid) begin
                buf_len_r <= buf_decode(desc_word[`RIW_DESC_LEN_HI:`RIW_DESC_LEN_LO], rxlen_r); // [R9]
            end
            // discard sticks until its own frame ends
            if (dma_end) begin
                dma_disc_pend_r <= 1'b0;
            end else if (desc_discard & ~desc_is_rx) begin
                dma_disc_pend_r <= 1'b1; // [R1]
            end
        end
    end

    // ****************************************
    // indication outputs
    // ****************************************
    always @(posedge clk) begin
        if (!rst_b) begin
            dst_ind_valid_r <= 1'b0;
            dst_ind_word_r <= 64'h0;
            rx_ind_valid_r <= 1'b0;
            rx_ind_word_r <= 64'h0;
            rx_ring_en_r <= `RIW_RING_EN_RST;
        end else begin
            dst_ind_valid_r <= dma_end | mk_ind; // [R2] [R8]
            if (dma_end | mk_ind) begin
                dst_ind_word_r <= dst_ind_nxt;
            end
            rx_ind_valid_r <= rx_ind_go; // [R19]
            if (rx_ind_go) begin
                rx_ind_word_r <= rx_ind_nxt;
            end
            // an overrun beats a software enable in the same cycle
            if (reg_wr && reg_addr == `RIW_REG_RING_EN) begin
                rx_ring_en_r <= reg_wdata[RINGS-1:0] & (ring_en_nxt | ~rx_ring_en_r); // [R20]
            end else begin
                rx_ring_en_r <= ring_en_nxt;
            end
        end
    end

    // ****************************************
    // register port
    // ****************************************
    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl_r <= `RIW_CTRL_RST;
            rxlen_r <= `RIW_RXLEN_RST;
            align_err_r <= 1'b0;
            reg_rdata_r <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `RIW_REG_CTRL) begin
                ctrl_r <= reg_wdata[1:0];
            end
            if (reg_wr && reg_addr == `RIW_REG_RXLEN) begin
                rxlen_r <= reg_wdata[13:0]; // [R10]
            end
            // a new misalignment wins over the clear
            if (desc_valid & misaligned) begin
                align_err_r <= 1'b1; // [R11]
            end else if (reg_wr && reg_addr == `RIW_REG_STATUS && reg_wdata[`RIW_STAT_ALIGN]) begin
                align_err_r <= 1'b0;
            end
            reg_rdata_r <= 32'h0;
            if (reg_rd) begin
                case (reg_addr)
                    `RIW_REG_CTRL: begin
                        reg_rdata_r <= {30'h0, ctrl_r};
                    end
                    `RIW_REG_RXLEN: begin
                        reg_rdata_r <= {18'h0, rxlen_r};
                    end
                    `RIW_REG_RING_EN: begin
                        reg_rdata_r <= {{(32-RINGS){1'b0}}, rx_ring_en_r};
                    end
                    `RIW_REG_STATUS: begin
                        reg_rdata_r <= {30'h0, dma_disc_pend_r, align_err_r};
                    end
                    `RIW_REG_DST_LO: begin
                        reg_rdata_r <= dst_ind_word_r[31:0];
                    end
                    `RIW_REG_DST_HI: begin
                        reg_rdata_r <= dst_ind_word_r[63:32];
                    end
                    `RIW_REG_RX_LO: begin
                        reg_rdata_r <= rx_ind_word_r[31:0];
                    end
                    `RIW_REG_RX_HI: begin
                        reg_rdata_r <= rx_ind_word_r[63:32];
                    end
                    default: begin
                        reg_rdata_r <= 32'h0;
                    end
                endcase
            end
        end
    end

endmodule // riw_ring_indication_writer
`default_nettype wire

// ---- tb/riw_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module riw_props #(
    parameter int RINGS = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // descriptor
    input wire logic desc_valid,
    input wire logic desc_is_rx,
    input wire logic [63:0] desc_word,
    input wire logic [13:0] buf_len_r,
    input wire logic buf_len_valid_r,
    input wire logic dma_discard_r,
    input wire logic rx_discard_r,
    // destination ring
    input wire logic dma_end,
    input wire logic [63:0] dma_src_desc,
    input wire logic dma_dst_parity,
    input wire logic mk_ind,
    input wire logic [23:0] mk_ind_field,
    input wire logic dst_ind_valid_r,
    input wire logic [63:0] dst_ind_word_r,
    // receive ring
    input wire logic rx_end,
    input wire logic [2:0] rx_ring,
    input wire logic rx_overrun,
    input wire logic rx_dev_abort,
    input wire logic rx_mac_side_interface_err,
    input wire logic rx_ind_valid_r,
    input wire logic [63:0] rx_ind_word_r,
    input wire logic [RINGS-1:0] rx_ring_en_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire rx_on = rx_end && rx_ring_en_r[rx_ring];

    len_decode_a:
    assert property (desc_valid && desc_word[39:32] == 8'h01 |=> buf_len_valid_r && buf_len_r == 14'h0040)
        else $error("bad length decode");
    rx_drop_a:
    assert property (desc_valid && desc_is_rx && desc_word[62] |=> rx_discard_r)
        else $error("rx discard missing");
    dma_drop_a:
    assert property (desc_valid && !desc_is_rx && desc_word[62] |=> dma_discard_r)
        else $error("dma discard missing");
    dst_copy_a:
    assert property (dma_end |=> dst_ind_valid_r && dst_ind_word_r[63:60] != 4'h3
        && dst_ind_word_r[35:24] == $past(dma_src_desc[59:48]) && dst_ind_word_r[47:45] == $past(dma_src_desc[47:45]))
        else $error("tag or command lost");
    dst_parity_a:
    assert property (dma_end && dma_dst_parity |=> dst_ind_word_r[63:60] == 4'h2 && dst_ind_word_r[54:52] == 3'b111)
        else $error("bad parity code");
    mk_copy_a:
    assert property (mk_ind && !dma_end |=> dst_ind_valid_r && dst_ind_word_r[23:0] == $past(mk_ind_field))
        else $error("make field lost");
    ovr_off_a:
    assert property (rx_on && rx_overrun |=> rx_ind_valid_r && rx_ind_word_r[57] && !rx_ring_en_r[$past(rx_ring)])
        else $error("overrun not handled");
    ring_off_a:
    assert property (rx_end && !rx_ring_en_r[rx_ring] |=> !rx_ind_valid_r)
        else $error("disabled ring reported");
    mac_side_interface_zero_a:
    assert property (rx_on && rx_mac_side_interface_err && rx_dev_abort |=> rx_ind_valid_r && rx_ind_word_r[55:48] == 8'h00)
        else $error("flag bits not zeroed");

    cover property (dst_ind_valid_r && dst_ind_word_r[63:60] == 4'h3);
    cover property (rx_on && rx_overrun);
    cover property (dma_discard_r);
endmodule // riw_props

bind riw_ring_indication_writer riw_props #(.RINGS(RINGS)) u_riw_props (.*);
`default_nettype wire

// ---- tb/riw_desc_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host ring model: hands out buffer descriptors
// ****************************************
module riw_desc_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // request from the bench
    input wire logic req,
    input wire logic rx,
    input wire logic [7:0] code,
    input wire logic disc,
    input wire logic wide,
    // descriptor toward the block
    output logic desc_valid,
    output logic desc_is_rx,
    output logic [63:0] desc_word
);
    logic [28:0] seq_r;
    always @(posedge clk) begin
        if (!rst_b) begin
            seq_r <= 29'h0;
            desc_valid <= 1'b0;
            desc_is_rx <= 1'b0;
            desc_word <= 64'h0;
        end else if (req) begin
            seq_r <= seq_r + 29'h1;
            desc_valid <= 1'b1;
            desc_is_rx <= rx;
            desc_word <= {1'b0, disc, 22'h0, code, seq_r, wide ? 3'h0 : 3'h4};
        end else begin
            // idle bus: no stale descriptor left standing
            desc_valid <= 1'b0;
            desc_is_rx <= ~desc_is_rx;
            desc_word <= ~desc_word;
        end
    end
endmodule // riw_desc_src
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "riw_defines.vh"
module tb_top;
    // ****************************************
    // stimulus and observed outputs
    // ****************************************
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, d_req = 1'b0, d_rx = 1'b0, d_disc = 1'b0;
    logic dma_end = 1'b0, dma_single = 1'b0, mk_ind = 1'b0, rx_end = 1'b0;
    logic [7:0] reg_addr = 8'h00, d_code = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [63:0] dma_src_desc = 64'h0;
    logic [15:0] dma_byte_count = 16'h0, rx_byte_count = 16'h0;
    logic [3:0] dma_err = 4'h0;
    logic [23:0] mk_ind_field = 24'h0;
    logic [2:0] rx_ring = 3'h0, rx_mac_status = 3'h0;
    logic [6:0] rx_bits = 7'h0;
    logic [5:0] rx_errs = 6'h0;
    wire desc_valid, desc_is_rx, buf_len_valid_r, dma_discard_r, rx_discard_r, dst_ind_valid_r, rx_ind_valid_r;
    wire [63:0] desc_word, dst_ind_word_r, rx_ind_word_r;
    wire [31:0] reg_rdata_r;
    wire [13:0] buf_len_r;
    wire [7:0] rx_ring_en_r;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    // rows: single split header crc local cam promisc, dest match code, length
    localparam logic [24:0] NORM [6] = '{{7'b1001100, 2'b11, 16'h0040}, {7'b0000010, 2'b01, 16'h05dc},
        {7'b1000001, 2'b10, 16'h0100}, {7'b1001000, 2'b00, 16'h0033}, {7'b1111100, 2'b00, 16'h000e},
        {7'b0101010, 2'b01, 16'h0200}};
    // rows: error causes, mac status in, status expected
    localparam logic [11:0] ERRS [3] = '{{6'b100000, 3'b110, 3'b110}, {6'b010000, 3'b000, 3'b011},
        {6'b001000, 3'b001, 3'b101}};
    localparam logic [2:0] PORT_ERROR_CODE [4] = '{3'b001, 3'b010, 3'b100, 3'b111};

    riw_desc_src u_riw_desc_src (.clk(clk), .rst_b(rst_b), .req(d_req), .rx(d_rx), .code(d_code), .disc(d_disc),
        .wide(1'b1), .desc_valid(desc_valid), .desc_is_rx(desc_is_rx), .desc_word(desc_word));
    riw_ring_indication_writer u_riw_ring_indication_writer (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .desc_valid(desc_valid), .desc_is_rx(desc_is_rx), .desc_word(desc_word), .buf_len_r(buf_len_r),
        .buf_len_valid_r(buf_len_valid_r), .dma_discard_r(dma_discard_r), .rx_discard_r(rx_discard_r),
        .dma_end(dma_end), .dma_src_desc(dma_src_desc), .dma_byte_count(dma_byte_count),
        .dma_single_buf(dma_single), .dma_src_abort(dma_err[3]), .dma_src_parity(dma_err[2]),
        .dma_dst_abort(dma_err[1]), .dma_dst_parity(dma_err[0]), .mk_ind(mk_ind), .mk_ind_field(mk_ind_field),
        .dst_ind_valid_r(dst_ind_valid_r), .dst_ind_word_r(dst_ind_word_r), .rx_end(rx_end), .rx_ring(rx_ring),
        .rx_byte_count(rx_byte_count), .rx_single_buf(rx_bits[6]), .rx_split(rx_bits[5]),
        .rx_header_part(rx_bits[4]), .rx_crc_err(rx_bits[3]), .rx_flags(8'h5a), .rx_match_local(rx_bits[2]),
        .rx_match_cam(rx_bits[1]), .rx_match_promisc(rx_bits[0]), .rx_mac_status(rx_mac_status),
        .rx_err_frame(rx_errs[5]), .rx_dev_abort(rx_errs[4]), .rx_frag_over_wm(rx_errs[3]),
        .rx_overrun(rx_errs[2]), .rx_parity(rx_errs[1]), .rx_mac_side_interface_err(rx_errs[0]),
        .rx_ind_valid_r(rx_ind_valid_r), .rx_ind_word_r(rx_ind_word_r), .rx_ring_en_r(rx_ring_en_r));

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            final_report;
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // drop pulses at the taking edge, look just after
    task automatic step;
        @(posedge clk);
        {reg_wr, reg_rd, d_req, dma_end, mk_ind, rx_end} <= 6'h00;
        #1;
    endtask
    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        step;
    endtask
    // model adds one cycle
    task automatic desc(input logic rx, input logic [7:0] code, input logic disc);
        @(posedge clk);
        d_req <= 1'b1;
        d_rx <= rx;
        d_code <= code;
        d_disc <= disc;
        step;
        @(posedge clk);
        #1;
    endtask
    task automatic dma(input logic [3:0] e);
        @(posedge clk);
        dma_end <= 1'b1;
        dma_err <= e;
        step;
    endtask
    task automatic rx(input logic [2:0] ring, input logic [6:0] b, input logic [5:0] e, input logic [2:0] st);
        @(posedge clk);
        rx_end <= 1'b1;
        rx_ring <= ring;
        rx_bits <= b;
        rx_errs <= e;
        rx_mac_status <= st;
        rx_byte_count <= 16'h0123;
        step;
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk({rx_ring_en_r, dst_ind_valid_r, rx_ind_valid_r}, {8'hff, 2'b00});
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            {rx_bits, rx_byte_count} <= {NORM[i][24:18], NORM[i][15:0]};
            rx_ring <= i[2:0];
            rx_errs <= 6'h00;
            rx_end <= 1'b1;
            step;
            chk({rx_ind_valid_r, rx_ind_word_r[63:57], rx_ind_word_r[55:46], rx_ind_word_r[15:0]},
                {1'b1, 4'h4, NORM[i][24:23], NORM[i][21] & ~NORM[i][22], NORM[i][22] ? 8'h00 : 8'h5a,
                NORM[i][17:0]});
        end
        reg_access(1'b0, `RIW_REG_RXLEN, 32'h0);
        chk(reg_rdata_r, 32'h0800);
        reg_access(1'b0, 8'h40, 32'h0);
        chk(reg_rdata_r, 32'h0);
        for (int i = 0; i < 8; i++) begin
            desc(i[0], 8'h01 << i, 1'b0);
            chk({buf_len_valid_r, buf_len_r}, {1'b1, 14'h0040 << i});
        end
        reg_access(1'b1, `RIW_REG_RXLEN, 32'h0123);
        desc(1'b1, 8'h00, 1'b0);
        chk(buf_len_r, 14'h0123);
        desc(1'b1, 8'h02, 1'b1);
        chk(rx_discard_r, 1'b1);
        dma_src_desc <= 64'h0abc_a000_0000_0000;
        dma_byte_count <= 16'h2005;
        dma_single <= 1'b1;
        dma(4'h0);
        chk({dst_ind_word_r[63:59], dst_ind_word_r[47:45], dst_ind_word_r[35:24], dst_ind_word_r[12:0]},
            {4'h1, 1'b1, 3'b101, 12'habc, 13'h0005});
        for (int i = 0; i < 4; i++) begin
            dma(4'b1000 >> i);
            chk({dst_ind_word_r[63:60], dst_ind_word_r[54:52]}, {4'h2, PORT_ERROR_CODE[i]});
        end
        desc(1'b0, 8'h01, 1'b1);
        chk(dma_discard_r, 1'b1);
        dma(4'h0);
        chk({dst_ind_word_r[63:60], dst_ind_word_r[54:52]}, {4'h2, 3'b100});
        @(posedge clk);
        dma_end <= 1'b1;
        @(posedge clk);
        dma_end <= 1'b0;
        mk_ind <= 1'b1;
        mk_ind_field <= 24'ha5c3e1;
        #1;
        chk(dst_ind_word_r[63:60], 4'h1);
        step;
        chk({dst_ind_word_r[63:60], dst_ind_word_r[23:0]}, {4'h3, 24'ha5c3e1});
        rx(3'h1, 7'h0, 6'b100000, 3'b110);
        chk(rx_ind_valid_r, 1'b0);
        reg_access(1'b1, `RIW_REG_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            rx(3'h1, 7'h0, ERRS[i][11:6], ERRS[i][5:3]);
            chk({rx_ind_valid_r, rx_ind_word_r[63:60], rx_ind_word_r[42:40]}, {5'h15, ERRS[i][2:0]});
        end
        rx(3'h3, 7'h0, 6'b010001, 3'b101);
        chk({rx_ind_word_r[63:60], rx_ind_word_r[55:48]}, {4'h5, 8'h00});
        rx(3'h2, 7'h0, 6'b000100, 3'b000);
        chk({rx_ind_word_r[63:60], rx_ind_word_r[57], rx_ring_en_r}, {4'h5, 1'b1, 8'hfb});
        rx(3'h2, 7'b1000100, 6'h00, 3'b000);
        chk(rx_ind_valid_r, 1'b0);
        reg_access(1'b0, `RIW_REG_RING_EN, 32'h0);
        chk(reg_rdata_r, 32'hfb);
        reg_access(1'b1, `RIW_REG_RING_EN, 32'hff);
        reg_access(1'b0, `RIW_REG_RING_EN, 32'h0);
        chk(reg_rdata_r, 32'hff);
        final_report;
    end
endmodule // tb_top
`default_nettype wire
